// [bench/fbw_ctrl_chk.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fbw_params.svh"

module fbw_ctrl_chk
  import fbw_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PSLVERR,
  // Commands
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire logic [2:0] CMD_OP,
  input wire logic [31:0] CMD_DATA,
  // Memory
  input wire logic MEM_REQ,
  input wire logic MEM_READY,
  input wire logic MEM_WE,
  input wire logic MEM_BLOCK,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_MASK,
  input wire logic [31:0] MEM_PIXEL_EN,
  // Video
  input wire logic [31:0] VIDEO_START,
  input wire logic VERTICAL_GAP,
  input wire logic [4:0] COLOR_FORMAT
);
  logic [31:0] mask_ff;
  logic [31:0] fill_ff;
  logic hold_ff;
  wire apb_wr = PSEL & PENABLE & PWRITE;
  wire cmd_go = CMD_VALID & CMD_READY;

  // Hold flag drops one cycle after the swap edge; that single cycle is excused below
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mask_ff <= `FBW_MASK_RST;
      fill_ff <= 32'h0;
      hold_ff <= 1'b0;
    end else begin
      if (apb_wr && PADDR == `FBW_ADDR_MEM_MASK) mask_ff <= PWDATA;
      if (cmd_go && CMD_OP == FBW_OP_SET_FILL) fill_ff <= CMD_DATA;
      if (cmd_go && CMD_OP == FBW_OP_HOLD) hold_ff <= 1'b1;
      else if ($rose(VERTICAL_GAP)) hold_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  mem_mask_a: assert property (MEM_REQ |-> MEM_MASK == mask_ff)
    else $error("memory mask not applied");
  block_fill_a: assert property (MEM_REQ && MEM_BLOCK |-> MEM_WE && MEM_WDATA == fill_ff)
    else $error("block write not of fill value");
  single_en_a: assert property (MEM_REQ && !MEM_BLOCK |-> MEM_PIXEL_EN == 32'h1)
    else $error("single access enables wrong");
  req_hold_a: assert property (MEM_REQ && !MEM_READY |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WDATA))
    else $error("memory request dropped or changed");
  hold_quiet_a: assert property (hold_ff |-> !MEM_REQ)
    else $error("memory access while swap held");
  hold_stall_a: assert property (hold_ff && !$rose(VERTICAL_GAP) && CMD_VALID && CMD_OP == FBW_OP_RENDER
    |-> !CMD_READY)
    else $error("render taken while swap held");
  busy_ready_a: assert property (MEM_REQ |-> !CMD_READY)
    else $error("command taken while engine busy");
  video_latch_a: assert property (!$stable(VIDEO_START) |-> $fell(VERTICAL_GAP))
    else $error("scan origin changed outside gap end");
  fmt_refuse_a: assert property (apb_wr && PADDR == `FBW_ADDR_COLOR_CFG && PWDATA[4:0] inside
    {`FBW_FMT_INDEX4, `FBW_FMT_LUMA_FULL, `FBW_FMT_LUMA_HALF} |-> PSLVERR ##1 $stable(COLOR_FORMAT))
    else $error("texture-only format accepted");

  cover property (MEM_REQ && MEM_READY && MEM_BLOCK);
  cover property (MEM_REQ && MEM_READY && !MEM_WE);
  cover property (hold_ff && $rose(VERTICAL_GAP));
endmodule : fbw_ctrl_chk
`default_nettype wire

// [bench/fbw_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module fbw_ctrl_tb_top
  import fbw_pkg::*;
;
  logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CMD_VALID, CMD_READY, CMD_BURST_FILL_ENABLE;
  logic MEM_REQ, MEM_WE, MEM_BLOCK, MEM_READY, MEM_RVALID, MEM_IDLE, VERTICAL_GAP, er;
  logic [15:0] PADDR, CMD_X, CMD_LEN;
  logic [31:0] PWDATA, PRDATA, CMD_DATA, CMD_ROW_ADDR, CMD_PATTERN, MEM_ADDR, MEM_WDATA, MEM_MASK;
  logic [31:0] MEM_PIXEL_EN, MEM_RDATA, VIDEO_START, rd, off, row, fill, ds, m, d, pat;
  logic [2:0] CMD_OP;
  logic [1:0] CMD_SHAPE_KIND;
  logic [4:0] COLOR_FORMAT, cf;
  logic [15:0] ra[6] = '{16'h3000, 16'h3004, 16'h3008, 16'h3014, 16'h3020, 16'h3040};
  logic [31:0] rv[5] = '{32'h0, 32'hffffffff, 32'hffffffff, 32'h2d, 32'hffff0000};
  logic [4:0] fm[5] = '{5'h0e, 5'h0f, 5'h12, 5'h13, 5'h03};
  logic [96:0] exq[$];
  logic [15:0] x;
  integer seed = 29884;
  integer failures = 0;
  integer checks_done = 0;
  int xmin = 0;
  int xmax = 65535;

  fbw_ctrl i_dut (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .CMD_VALID, .CMD_READY, .CMD_OP, .CMD_DATA, .CMD_ROW_ADDR, .CMD_X, .CMD_LEN, .CMD_SHAPE_KIND,
    .CMD_BURST_FILL_ENABLE, .CMD_PATTERN, .MEM_REQ, .MEM_WE, .MEM_BLOCK, .MEM_ADDR, .MEM_WDATA,
    .MEM_MASK, .MEM_PIXEL_EN, .MEM_READY, .MEM_RVALID, .MEM_RDATA, .MEM_IDLE, .VIDEO_START,
    .VERTICAL_GAP, .COLOR_FORMAT);
  fbw_mem_model i_mem (.clk(CLK), .rst(RESET), .req(MEM_REQ), .we(MEM_WE), .blk(MEM_BLOCK),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .en(MEM_PIXEL_EN), .ready(MEM_READY), .rvalid(MEM_RVALID),
    .rdata(MEM_RDATA), .idle(MEM_IDLE));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [96:0] e, input logic [96:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] dt);
    integer n;
    n = 0;
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, dt};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
      @(posedge CLK);
    while (PREADY !== 1'b1 && ++n < 50);
    if (PREADY !== 1'b1) failures++;
    rd = PRDATA;
    er = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask : apb

  // Ready is looked at mid-cycle, where it has settled for the coming edge
  task automatic cmd(input logic [2:0] op, input logic [31:0] dt, input logic [15:0] cx, input logic [15:0] len,
                     input logic [1:0] sh, input logic bf);
    logic r;
    integer n;
    n = 0;
    @(posedge CLK);
    {CMD_VALID, CMD_OP, CMD_DATA, CMD_ROW_ADDR, CMD_X, CMD_LEN, CMD_SHAPE_KIND, CMD_BURST_FILL_ENABLE,
     CMD_PATTERN} <= {1'b1, op, dt, row, cx, len, sh, bf, pat};
    do begin
      @(negedge CLK);
      r = CMD_READY;
      @(posedge CLK);
    end while (r !== 1'b1 && ++n < 5000);
    if (r !== 1'b1) failures++;
    CMD_VALID <= 1'b0;
  endtask : cmd

  task automatic exp_span(input logic blk, input logic mg, input logic [15:0] cx, input logic [15:0] len);
    logic [31:0] c;
    logic [31:0] a;
    for (int b = cx & ~31; b < cx + len; b += 32) begin
      c = 32'h0;
      for (int i = 0; i < 32; i++)
        if (b + i >= cx && b + i < cx + len && b + i >= xmin && b + i <= xmax) begin
          c[i] = 1'b1;
          a = row + b + i + off;
          if (!blk) exq.push_back({1'b0, a, mg ? (((a ^ 32'h5a5a5a5a) & ~m) | (d & m)) : d, 32'h1});
        end
      if (blk && c != 0) exq.push_back({1'b1, row + b + off, fill, c & pat});
    end
  endtask : exp_span

  task automatic drain();
    integer n;
    n = 0;
    while (i_mem.wq.size() < exq.size() && n++ < 3000) @(posedge CLK);
    repeat (20) @(posedge CLK);
    chk("mem_count", exq.size(), i_mem.wq.size());
    while (exq.size() > 0 && i_mem.wq.size() > 0) chk("mem_access", exq.pop_front(), i_mem.wq.pop_front());
    exq.delete();
    i_mem.wq.delete();
  endtask : drain

  task automatic wait_fall();
    integer n;
    n = 0;
    while (VERTICAL_GAP !== 1'b1 && n++ < 4000) @(posedge CLK);
    while (VERTICAL_GAP !== 1'b0 && n++ < 4000) @(posedge CLK);
    if (VERTICAL_GAP !== 1'b0) failures++;
    repeat (2) @(posedge CLK);
  endtask : wait_fall

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    RESET = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {CMD_VALID, CMD_OP, CMD_DATA, CMD_ROW_ADDR, CMD_X, CMD_LEN, CMD_SHAPE_KIND, CMD_BURST_FILL_ENABLE} = '0;
    {CMD_PATTERN, off, row, pat, d, m, cf} = '0;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("rd_err", i == 5, er);
      if (i < 5) chk("rd_reset", rv[i], rd);
    end
    ds = $random(seed);
    apb(1'b1, 16'h3000, ds);
    apb(1'b0, 16'h3000, 32'h0);
    chk("disp_start", ds, rd);
    chk("video_old", 32'h0, VIDEO_START);
    apb(1'b1, 16'h3024, 32'h3);
    apb(1'b1, 16'h3014, 32'h1);
    wait_fall();
    chk("video_new", ds, VIDEO_START);
    apb(1'b0, 16'h3010, 32'h0);
    chk("scanline", 32'h1, rd);
    chk("vgap", 1'b0, VERTICAL_GAP);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 16'h301c, {27'h0, fm[i]});
      chk("fmt_err", fm[i] inside {5'h0f, 5'h12, 5'h13}, er);
      if (!(fm[i] inside {5'h0f, 5'h12, 5'h13})) cf = fm[i];
      apb(1'b0, 16'h301c, 32'h0);
      chk("fmt_reg", cf, rd[4:0]);
      chk("fmt_out", cf, COLOR_FORMAT);
    end
    apb(1'b0, 16'h3018, 32'h0);
    chk("fmt_flag", 1'b1, rd[2]);
    off = $random(seed);
    row = $random(seed) & ~32'h1f;
    cmd(FBW_OP_SET_OFFSET, off, 16'h0, 16'h0, 2'h0, 1'b0);
    // Empty span first, then a plain span, then wrong shape with fill, then trapezoid without fill
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      x = $random(seed) & 63;
      cmd(FBW_OP_RENDER, d, x, k == 0 ? 16'h0 : 16'h3 + k, k == 3 ? 2'h2 : 2'h1, k == 2);
      exp_span(1'b0, 1'b0, x, k == 0 ? 16'h0 : 16'h3 + k);
    end
    drain();
    m = $random(seed);
    d = $random(seed);
    apb(1'b1, 16'h3008, m);
    apb(1'b1, 16'h300c, 32'h2);
    cmd(FBW_OP_RENDER, d, 16'h5, 16'h3, 2'h1, 1'b0);
    exp_span(1'b0, 1'b1, 16'h5, 16'h3);
    drain();
    apb(1'b1, 16'h300c, 32'h0);
    apb(1'b1, 16'h3008, 32'hffffffff);
    apb(1'b1, 16'h3004, $random(seed));
    xmin = 12;
    xmax = 70;
    apb(1'b1, 16'h3020, {xmax[15:0], xmin[15:0]});
    fill = $random(seed);
    cmd(FBW_OP_SET_FILL, fill, 16'h0, 16'h0, 2'h0, 1'b0);
    pat = $random(seed) | 32'h01010101;
    cmd(FBW_OP_RENDER, $random(seed), 16'd10, 16'd40, `FBW_SHAPE_TRAPEZOID, 1'b1);
    cmd(FBW_OP_RENDER, $random(seed), 16'd0, 16'd96, `FBW_SHAPE_TRAPEZOID, 1'b1);
    cmd(FBW_OP_RENDER, $random(seed), 16'd40, 16'd5, `FBW_SHAPE_TRAPEZOID, 1'b1);
    exp_span(1'b1, 1'b0, 16'd10, 16'd40);
    exp_span(1'b1, 1'b0, 16'd0, 16'd96);
    exp_span(1'b1, 1'b0, 16'd40, 16'd5);
    drain();
    wait_fall();
    fill = $random(seed) & ~32'h1f;
    cmd(FBW_OP_HOLD, fill, 16'h0, 16'h0, 2'h0, 1'b0);
    cmd(FBW_OP_OTHER, 32'h0, 16'h0, 16'h0, 2'h0, 1'b0);
    apb(1'b0, 16'h3018, 32'h0);
    chk("pending", 1'b1, rd[0]);
    apb(1'b0, 16'h3000, 32'h0);
    chk("start_before", ds, rd);
    d = $random(seed);
    cmd(FBW_OP_RENDER, d, 16'd20, 16'd2, 2'h1, 1'b0);
    apb(1'b0, 16'h3000, 32'h0);
    chk("start_after", fill, rd);
    exp_span(1'b0, 1'b0, 16'd20, 16'd2);
    drain();
    wait_fall();
    chk("video_swap", fill, VIDEO_START);
    close_out();
  end

  initial begin
    repeat (40000) @(posedge CLK);
    failures++;
    close_out();
  end
endmodule : fbw_ctrl_tb_top

bind fbw_ctrl fbw_ctrl_chk i_chk (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSLVERR,
  .CMD_VALID, .CMD_READY, .CMD_OP, .CMD_DATA, .MEM_REQ, .MEM_READY, .MEM_WE, .MEM_BLOCK, .MEM_ADDR,
  .MEM_WDATA, .MEM_MASK, .MEM_PIXEL_EN, .VIDEO_START, .VERTICAL_GAP, .COLOR_FORMAT);
`default_nettype wire

// [bench/fbw_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none

module fbw_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  input wire logic req,
  input wire logic we,
  input wire logic blk,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] en,
  // Answer side
  output logic ready,
  output logic rvalid,
  output logic [31:0] rdata,
  output logic idle
);
  logic go_ff;
  logic [96:0] wq[$];
  wire rd_go = req & ready & ~we;

  // Alternate prompt and late answers so both paths are exercised
  assign ready = req & go_ff;
  assign idle = ~rvalid;

  // Outside a read answer the data lines keep moving, never holding old data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      go_ff <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
    end else begin
      go_ff <= ~go_ff;
      rvalid <= rd_go;
      rdata <= rd_go ? (addr ^ 32'h5a5a5a5a) : ~rdata;
      if (req & ready & we) wq.push_back({blk, addr, wdata, en});
    end
  end
endmodule : fbw_mem_model
`default_nettype wire

// [src/fbw_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fbw_params.svh"

module fbw_ctrl
  import fbw_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Command stream head
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [2:0] CMD_OP,
  input wire logic [31:0] CMD_DATA,
  input wire logic [31:0] CMD_ROW_ADDR,
  input wire logic [15:0] CMD_X,
  input wire logic [15:0] CMD_LEN,
  input wire logic [1:0] CMD_SHAPE_KIND,
  input wire logic CMD_BURST_FILL_ENABLE,
  input wire logic [31:0] CMD_PATTERN,
  // Framebuffer memory port
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_BLOCK,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  output logic [31:0] MEM_MASK,
  output logic [31:0] MEM_PIXEL_EN,
  input wire logic MEM_READY,
  input wire logic MEM_RVALID,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_IDLE,
  // Video and color outputs
  output logic [31:0] VIDEO_START,
  output logic VERTICAL_GAP,
  output logic [4:0] COLOR_FORMAT
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  fbw_state_t state_ff, nxt_state;
  logic [31:0] display_start_ff, mem_mask_ff, merge_mask_ff, scissor_ff;
  logic [31:0] render_offset_ff, fill_value_ff, hold_data_ff, video_start_ff;
  logic [31:0] prdata_ff, row_ff, pix_ff, pat_ff, rd_ff;
  logic [1:0] fetch_ff;
  logic [4:0] color_cfg_ff;
  logic fmt_err_ff, pslverr_ff, pending_ff;
  logic [15:0] vgap_end_ff, frame_lines_ff, scan_ff, line_div_ff;
  logic [15:0] cur_ff, hi_ff, lo_ff;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup = PSEL && !PENABLE;
  wire wr_acc = PSEL && PENABLE && PWRITE;
  wire hit_ds = PADDR == `FBW_ADDR_DISPLAY_START;
  wire hit_mm = PADDR == `FBW_ADDR_MEM_MASK;
  wire hit_gm = PADDR == `FBW_ADDR_MERGE_MASK;
  wire hit_fc = PADDR == `FBW_ADDR_FETCH_CFG;
  wire hit_sl = PADDR == `FBW_ADDR_SCANLINE;
  wire hit_ve = PADDR == `FBW_ADDR_VGAP_END;
  wire hit_st = PADDR == `FBW_ADDR_STATUS;
  wire hit_cc = PADDR == `FBW_ADDR_COLOR_CFG;
  wire hit_sc = PADDR == `FBW_ADDR_SCISSOR;
  wire hit_fl = PADDR == `FBW_ADDR_FRAME_LINES;
  wire hit_ro = PADDR == `FBW_ADDR_RENDER_OFFSET;
  wire hit_fv = PADDR == `FBW_ADDR_FILL_VALUE;
  wire mapped = hit_ds | hit_mm | hit_gm | hit_fc | hit_sl | hit_ve | hit_st | hit_cc |
                hit_sc | hit_fl | hit_ro | hit_fv;
  wire [4:0] fmt_in = PWDATA[4:0];
  wire fmt_bad = fmt_in == `FBW_FMT_INDEX4 || fmt_in == `FBW_FMT_LUMA_FULL ||
                 fmt_in == `FBW_FMT_LUMA_HALF;
  wire ro_hit = hit_sl | hit_st | hit_ro | hit_fv;
  wire bad_wr = PWRITE && (ro_hit || (hit_cc && fmt_bad));
  wire busy = !(state_ff == FBW_IDLE);
  wire [31:0] status = {28'h0000000, VERTICAL_GAP, fmt_err_ff, busy, pending_ff};
  wire [31:0] rd_mux = hit_ds ? display_start_ff :
                       hit_mm ? mem_mask_ff :
                       hit_gm ? merge_mask_ff :
                       hit_fc ? {30'h00000000, fetch_ff} :
                       hit_sl ? {16'h0000, scan_ff} :
                       hit_ve ? {16'h0000, vgap_end_ff} :
                       hit_st ? status :
                       hit_cc ? {27'h0000000, color_cfg_ff} :
                       hit_sc ? scissor_ff :
                       hit_fl ? {16'h0000, frame_lines_ff} :
                       hit_ro ? render_offset_ff :
                       hit_fv ? fill_value_ff : 32'h00000000;

  // Zero wait states: data is prepared in the setup cycle
  assign PREADY = 1'b1;
  assign PRDATA = prdata_ff;
  assign PSLVERR = pslverr_ff;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= PWRITE ? 32'h00000000 : rd_mux;
      pslverr_ff <= !mapped || bad_wr;
    end
  end

  // ----------------------------------------------------------------
  // Video timing: scanline counter and display start
  // ----------------------------------------------------------------
  wire line_tick = line_div_ff == 16'(`FBW_LINE_CYCLES - 1);
  wire frame_wrap = line_tick && (scan_ff >= frame_lines_ff - 16'h0001);
  wire [15:0] nxt_scan = frame_wrap ? 16'h0000 : scan_ff + 16'h0001;
  wire gap_end = line_tick && (nxt_scan == vgap_end_ff);
  wire swap_now = frame_wrap && pending_ff;

  assign VERTICAL_GAP = scan_ff < vgap_end_ff;
  assign VIDEO_START = video_start_ff;
  assign COLOR_FORMAT = color_cfg_ff;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      line_div_ff <= 16'h0000;
      scan_ff <= 16'h0000;
    end else begin
      line_div_ff <= line_tick ? 16'h0000 : line_div_ff + 16'h0001;
      if (line_tick)
        scan_ff <= nxt_scan;
    end
  end

  // Only the end of the vertical gap moves the scan-out origin, so a host write never tears
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET)
      video_start_ff <= `FBW_DISPLAY_START_RST;
    else if (gap_end)
      video_start_ff <= display_start_ff;
  end

  // Hold data wins over a host write landing in the same cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET)
      display_start_ff <= `FBW_DISPLAY_START_RST;
    else if (swap_now)
      display_start_ff <= hold_data_ff;
    else if (wr_acc && hit_ds)
      display_start_ff <= PWDATA;
  end

  // ----------------------------------------------------------------
  // Host-written configuration
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mem_mask_ff <= `FBW_MASK_RST;
      merge_mask_ff <= `FBW_MASK_RST;
      fetch_ff <= `FBW_FETCH_RST;
      vgap_end_ff <= `FBW_VGAP_END_RST;
      frame_lines_ff <= `FBW_FRAME_LINES_RST;
      scissor_ff <= `FBW_SCISSOR_RST;
    end else if (wr_acc) begin
      if (hit_mm) mem_mask_ff <= PWDATA;
      if (hit_gm) merge_mask_ff <= PWDATA;
      if (hit_fc) fetch_ff <= PWDATA[1:0];
      if (hit_ve) vgap_end_ff <= PWDATA[15:0];
      if (hit_fl) frame_lines_ff <= PWDATA[15:0];
      if (hit_sc) scissor_ff <= PWDATA;
    end
  end

  // A refused format leaves the previous one in place and raises a sticky flag
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      color_cfg_ff <= `FBW_COLOR_CFG_RST;
      fmt_err_ff <= 1'b0;
    end else if (wr_acc && hit_cc) begin
      if (fmt_bad)
        fmt_err_ff <= 1'b1;
      else
        color_cfg_ff <= fmt_in;
    end else if (wr_acc && hit_st && PWDATA[`FBW_STAT_FMT_ERR_BIT])
      fmt_err_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Command head
  // ----------------------------------------------------------------
  wire is_render = CMD_OP == FBW_OP_RENDER;
  wire render_ok = !pending_ff;
  assign CMD_READY = (state_ff == FBW_IDLE) && (!is_render || render_ok);
  wire take = CMD_VALID && CMD_READY;
  wire take_render = take && is_render;
  wire take_hold = take && CMD_OP == FBW_OP_HOLD;
  wire block_mode = CMD_SHAPE_KIND == `FBW_SHAPE_TRAPEZOID && CMD_BURST_FILL_ENABLE;
  logic blk_ff;

  // Scissor clip of the span extent
  wire [15:0] sc_min = scissor_ff[15:0];
  wire [15:0] sc_max = scissor_ff[31:16];
  wire [15:0] span_end = CMD_X + CMD_LEN;
  wire [15:0] clip_lo = (CMD_X > sc_min) ? CMD_X : sc_min;
  wire [15:0] clip_hi = (span_end > sc_max) ? sc_max + 16'h0001 : span_end;
  wire span_empty = clip_lo >= clip_hi;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      render_offset_ff <= 32'h00000000;
      fill_value_ff <= 32'h00000000;
    end else if (take && CMD_OP == FBW_OP_SET_OFFSET)
      render_offset_ff <= CMD_DATA;
    else if (take && CMD_OP == FBW_OP_SET_FILL)
      fill_value_ff <= CMD_DATA;
  end

  // Pending is set after the flush and cleared only by the frame-boundary swap
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pending_ff <= 1'b0;
      hold_data_ff <= 32'h00000000;
    end else begin
      if (take_hold)
        hold_data_ff <= CMD_DATA;
      if (state_ff == FBW_FLUSH && MEM_IDLE)
        pending_ff <= 1'b1;
      else if (swap_now)
        pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      row_ff <= 32'h00000000;
      pix_ff <= 32'h00000000;
      pat_ff <= 32'h00000000;
      lo_ff <= 16'h0000;
      hi_ff <= 16'h0000;
      blk_ff <= 1'b0;
    end else if (take_render) begin
      row_ff <= CMD_ROW_ADDR;
      pix_ff <= CMD_DATA;
      pat_ff <= CMD_PATTERN;
      lo_ff <= clip_lo;
      hi_ff <= clip_hi;
      blk_ff <= block_mode;
    end
  end

  // ----------------------------------------------------------------
  // Pixel engine
  // ----------------------------------------------------------------
  wire dst_fetch = fetch_ff[`FBW_FETCH_DST_BIT];
  wire [15:0] blk_x = cur_ff & ~(`FBW_BLOCK_PIXELS - 16'h0001);
  wire [15:0] nxt_blk_x = blk_x + `FBW_BLOCK_PIXELS;
  wire [15:0] x_sel = (state_ff == FBW_BLOCK) ? blk_x : cur_ff;
  wire [31:0] pix_addr = row_ff + {16'h0000, x_sel} + render_offset_ff;
  wire [31:0] merged = (rd_ff & ~merge_mask_ff) | (pix_ff & merge_mask_ff);
  logic [31:0] blk_en;

  // Edge blocks are trimmed to the clipped span
  always_comb begin
    blk_en = 32'h00000000;
    for (int i = 0; i < 32; i++)
      blk_en[i] = (blk_x + 16'(i) >= lo_ff) && (blk_x + 16'(i) < hi_ff) && pat_ff[i];
  end

  assign MEM_REQ = state_ff == FBW_RD_REQ || state_ff == FBW_WR_REQ || state_ff == FBW_BLOCK;
  assign MEM_WE = state_ff == FBW_WR_REQ || state_ff == FBW_BLOCK;
  assign MEM_BLOCK = state_ff == FBW_BLOCK;
  assign MEM_ADDR = pix_addr;
  // Block data is the fill value alone; depth, stencil and color ops never reach it
  assign MEM_WDATA = (state_ff == FBW_BLOCK) ? fill_value_ff : (dst_fetch ? merged : pix_ff);
  // Memory-level mask rides on every write; merge only exists on the read path
  assign MEM_MASK = mem_mask_ff;
  assign MEM_PIXEL_EN = (state_ff == FBW_BLOCK) ? blk_en : 32'h00000001;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FBW_IDLE: begin
        if (take_hold)
          nxt_state = FBW_FLUSH;
        else if (take_render && !span_empty)
          nxt_state = block_mode ? FBW_BLOCK : (dst_fetch ? FBW_RD_REQ : FBW_WR_REQ);
      end
      FBW_FLUSH: begin
        if (MEM_IDLE)
          nxt_state = FBW_IDLE;
      end
      FBW_RD_REQ: begin
        if (MEM_READY)
          nxt_state = FBW_RD_WAIT;
      end
      FBW_RD_WAIT: begin
        if (MEM_RVALID)
          nxt_state = FBW_WR_REQ;
      end
      FBW_WR_REQ: begin
        if (MEM_READY)
          nxt_state = (cur_ff + 16'h0001 >= hi_ff) ? FBW_IDLE : (dst_fetch ? FBW_RD_REQ : FBW_WR_REQ);
      end
      FBW_BLOCK: begin
        if (MEM_READY && nxt_blk_x >= hi_ff)
          nxt_state = FBW_IDLE;
      end
      default: nxt_state = FBW_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET)
      state_ff <= FBW_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET)
      cur_ff <= 16'h0000;
    else if (take_render)
      cur_ff <= clip_lo;
    else if (MEM_READY && state_ff == FBW_WR_REQ)
      cur_ff <= cur_ff + 16'h0001;
    else if (MEM_READY && state_ff == FBW_BLOCK)
      cur_ff <= nxt_blk_x;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET)
      rd_ff <= 32'h00000000;
    else if (state_ff == FBW_RD_WAIT && MEM_RVALID)
      rd_ff <= MEM_RDATA;
  end

endmodule : fbw_ctrl
`default_nettype wire

// [src/fbw_params.svh]
`ifndef FBW_PARAMS_SVH
`define FBW_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FBW_ADDR_DISPLAY_START 16'h3000
`define FBW_ADDR_MEM_MASK 16'h3004
`define FBW_ADDR_MERGE_MASK 16'h3008
`define FBW_ADDR_FETCH_CFG 16'h300c
`define FBW_ADDR_SCANLINE 16'h3010
`define FBW_ADDR_VGAP_END 16'h3014
`define FBW_ADDR_STATUS 16'h3018
`define FBW_ADDR_COLOR_CFG 16'h301c
`define FBW_ADDR_SCISSOR 16'h3020
`define FBW_ADDR_FRAME_LINES 16'h3024
`define FBW_ADDR_RENDER_OFFSET 16'h3028
`define FBW_ADDR_FILL_VALUE 16'h302c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FBW_FETCH_SRC_BIT 0
`define FBW_FETCH_DST_BIT 1
`define FBW_STAT_PENDING_BIT 0
`define FBW_STAT_BUSY_BIT 1
`define FBW_STAT_FMT_ERR_BIT 2
`define FBW_STAT_VGAP_BIT 3

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define FBW_DISPLAY_START_RST 32'h00000000
`define FBW_MASK_RST 32'hffffffff
`define FBW_FETCH_RST 2'h0
`define FBW_VGAP_END_RST 16'h002d
`define FBW_FRAME_LINES_RST 16'h020d
`define FBW_SCISSOR_RST 32'hffff0000
`define FBW_COLOR_CFG_RST 5'h00
`define FBW_FMT_INDEX4 5'h0f
`define FBW_FMT_LUMA_FULL 5'h12
`define FBW_FMT_LUMA_HALF 5'h13
`define FBW_SHAPE_TRAPEZOID 2'h2
`define FBW_BLOCK_PIXELS 16'h0020

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FBW_CLK_PERIOD_NS 100
`define FBW_LINE_TIME_NS 64000
`define FBW_LINE_CYCLES (`FBW_LINE_TIME_NS / `FBW_CLK_PERIOD_NS)

`endif

// [src/fbw_pkg.sv]
package fbw_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    FBW_IDLE = 6'h01,
    FBW_FLUSH = 6'h02,
    FBW_RD_REQ = 6'h04,
    FBW_RD_WAIT = 6'h08,
    FBW_WR_REQ = 6'h10,
    FBW_BLOCK = 6'h20
  } fbw_state_t;

  typedef enum logic [2:0] {
    FBW_OP_NOP = 3'h0,
    FBW_OP_SET_OFFSET = 3'h1,
    FBW_OP_SET_FILL = 3'h2,
    FBW_OP_HOLD = 3'h3,
    FBW_OP_RENDER = 3'h4,
    FBW_OP_OTHER = 3'h5
  } fbw_op_t;

endpackage : fbw_pkg
